/* File: hw/hecd_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the configuration decoder.
// Assumes: Byte addresses count from the start of the configuration image.
// Notes: Definitions only.
`ifndef HECD_PARAMS_SVH
`define HECD_PARAMS_SVH
`define HECD_LOAD_MARKER      8'hD4
`define HECD_BYTE_DELAY       11'h010
`define HECD_BYTE_FLAGS_A     11'h011
`define HECD_BYTE_FLAGS_B     11'h012
`define HECD_BYTE_PROTECT     11'h013
`define HECD_BYTE_LANGS       11'h014
`define HECD_BYTE_STRINGS     11'h015
`define HECD_BYTE_ACTIVE      11'h016
`define HECD_BYTE_REMOVABLE   11'h017
`define HECD_LANG_TABLE_BASE  11'h018
`define HECD_DEF_DELAY        8'h32
`define HECD_DEF_FLAGS_A      8'h80
`define HECD_DEF_FLAGS_B      8'h00
`define HECD_DEF_PROTECT      8'h00
`define HECD_DEF_LANGS        8'h00
`define HECD_DEF_STRINGS      8'h00
`define HECD_DEF_ACTIVE       8'h0F
`define HECD_DEF_REMOVABLE    8'h0F
`define HECD_FLAGS_A_MASK     8'hF4
`define HECD_STRINGS_MASK     8'h3F
`define HECD_PORT_MASK        8'h0F
`define HECD_PROTECT_MARKER   8'h42
`define HECD_HUB_DESC_TYPE    8'h29
`define HECD_MAX_LANGS        8'h1F
`define HECD_DELAY_UNIT_MS    2
`define HECD_CLK_HZ           20000000
`define HECD_CHOP_HZ          120
`define HECD_CHOP_HALF_CYCLES (`HECD_CLK_HZ / (2 * `HECD_CHOP_HZ))
`define HECD_REG_STATUS       12'h000
`define HECD_REG_CFG_LOW      12'h004
`define HECD_REG_CFG_HIGH     12'h008
`define HECD_REG_HUB_CHAR     12'h00C
`define HECD_REG_PORT_CTRL    12'h010
`define HECD_REG_FAULT        12'h014
`define HECD_REG_LANG_SEL     12'h018
`define HECD_REG_LANG_CODE    12'h01C
`define HECD_REG_TABLE_BASE   12'h020
`endif

/* File: hw/hecd_pkg.sv */
// Purpose: Types shared by the configuration decoder.
// Assumes: Nothing beyond the parameter header.
// Notes: Holds types only.
package hecd_pkg;
  typedef enum logic [1:0] {
    HECD_ST_LOAD = 2'b01,
    HECD_ST_DONE = 2'b10
  } hecd_state_type;

  typedef struct packed {
    logic [7:0] power_good_delay;
    logic       accept_zero_desc_type;
    logic       compound_flag;
    logic       full_speed_only;
    logic       indicators_off;
    logic       shared_power_switch;
    logic       amber_level_sel;
    logic       green_level_sel;
    logic       local_supply_capable;
    logic       indicator_chop_en;
    logic       power_switch_level_sel;
    logic       fault_input_level_sel;
    logic       fault_detect_disable;
    logic       fault_per_port_sel;
    logic       write_protected;
    logic [7:0] language_count;
    logic       strings_enabled;
    logic [5:0] string_presence_mask;
    logic [3:0] usable_port_mask;
    logic [3:0] detachable_port_mask;
  } hecd_cfg_type;
endpackage

/* File: hw/hecd_decoder.sv */
// Purpose: Decodes the upper configuration image bytes and applies them to hub-facing controls.
// Assumes: The image loader delivers bytes with their addresses, byte 0 first, then pulses load_done.
// Notes: Registers sit on APB with zero wait states.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
`include "hecd_params.svh"
// How it works
// - Byte 16 is the power-good delay in 2 ms steps, default 100 ms.
// - Descriptor type zero accepted when byte 17 bit 7 set, otherwise refused.
// - Byte 17 bit 6 compound flag appears in hub characteristics bit 2.
// - Byte 17 bit 5 forces full-speed-only operation.
// - Byte 17 bit 4 kills indicators and clears characteristics bit 7.
// - Byte 17 bit 2 picks ganged or per-port power switching in characteristics.
// - Byte 18 bits 7 and 6 set amber and green indicator active levels.
// - Byte 18 bit 5 says whether self powered operation is possible.
// - Byte 18 bit 4 chops indicators with a 120 Hz square wave.
// - Byte 18 bit 3 sets power control output active level.
// - Byte 18 bit 2 sets overcurrent input active level.
// - Byte 18 bit 1 disables overcurrent detection, shown in characteristics bit 4.
// - Byte 18 bit 0 picks per-port or summed reporting, characteristics bit 3.
// - Byte 19 equal to the protect marker refuses all later EEPROM writes.
// - Byte 20 language count; zero or above 31 disables strings.
// - Byte 21 bitmap gives nonzero string index when set, zero when clear.
// - Byte 22 usable port mask; reported port count is its set bits.
// - Active ports numbered consecutively; byte 23 gives the removable field.
// - Language codes from byte 24, two bytes each, low byte first.
// - Six pointer tables follow, each two times the language count after the previous.
module hecd_decoder
  import hecd_pkg::*;
#(
  parameter int CHOP_HALF_CYCLES = `HECD_CHOP_HALF_CYCLES,
  parameter int NUM_PORTS        = 4
) (
  // Clock and reset.
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  // APB slave.
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  output logic       [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  // Image bytes from the EEPROM reader.
  input  wire  logic        load_byte_valid,
  input  wire  logic [10:0] load_byte_addr,
  input  wire  logic [7:0]  load_byte_data,
  input  wire  logic        load_done,
  // Hub core side.
  input  wire  logic [7:0]  desc_req_type,
  output logic              desc_type_ok,
  output logic              config_ready,
  output hecd_cfg_type      cfg,
  output logic       [15:0] hub_characteristics,
  output logic       [2:0]  port_count,
  output logic       [4:0]  device_removable,
  output logic       [11:0] logical_port_num,
  output logic       [47:0] string_index,
  output logic       [65:0] string_table_base,
  output logic              eeprom_write_allow,
  // Port pins.
  output logic       [3:0]  amber_out,
  output logic       [3:0]  green_out,
  output logic       [3:0]  power_out,
  input  wire  logic [3:0]  fault_in,
  output logic       [3:0]  port_fault
);

  // Elaboration refuses port counts and chop periods that the fixed-width logic cannot serve.
  if (NUM_PORTS != 4 || CHOP_HALF_CYCLES < 1 || CHOP_HALF_CYCLES > 131071) begin : g_bad_params
    $error("hecd_decoder: unsupported parameter values");
  end

  hecd_state_type state_reg, state_next;
  logic [7:0]  byte_reg [8];
  logic [7:0]  byte_next [8];
  logic        marker_ok_reg, marker_ok_next;
  logic [15:0] lang_reg [31];
  logic [15:0] lang_next [31];
  logic [11:0] ctrl_reg, ctrl_next;
  logic [4:0]  lang_sel_reg, lang_sel_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [16:0] chop_cnt_reg, chop_cnt_next;
  logic        chop_phase_reg, chop_phase_next;
  logic [10:0] lang_off;
  logic [4:0]  lang_idx;

  assign lang_off = load_byte_addr - `HECD_LANG_TABLE_BASE;
  assign lang_idx = lang_off[5:1];

  // Loader: bytes are taken only while loading and only behind a good marker.
  always_comb begin
    state_next     = state_reg;
    marker_ok_next = marker_ok_reg;
    for (int i = 0; i < 8; i++) begin
      byte_next[i] = byte_reg[i];
    end
    for (int j = 0; j < 31; j++) begin
      lang_next[j] = lang_reg[j];
    end
    case (state_reg)
      HECD_ST_LOAD: begin
        if (load_byte_valid && load_byte_addr == 11'h000) begin
          marker_ok_next = (load_byte_data == `HECD_LOAD_MARKER);
        end else if (load_byte_valid && marker_ok_reg) begin
          if (load_byte_addr >= `HECD_BYTE_DELAY && load_byte_addr <= `HECD_BYTE_REMOVABLE) begin
            byte_next[load_byte_addr[2:0]] = load_byte_data;
          end else if (load_byte_addr >= `HECD_LANG_TABLE_BASE && lang_off < 11'd62) begin
            if (lang_off[0]) begin
              lang_next[lang_idx][15:8] = load_byte_data;
            end else begin
              lang_next[lang_idx][7:0] = load_byte_data;
            end
          end
        end
        if (load_done) begin
          state_next = HECD_ST_DONE;
        end
      end
      HECD_ST_DONE: begin
        state_next = HECD_ST_DONE;
      end
      default: begin
        state_next = HECD_ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= HECD_ST_LOAD;
      marker_ok_reg <= 1'b0;
      byte_reg[0]   <= `HECD_DEF_DELAY;
      byte_reg[1]   <= `HECD_DEF_FLAGS_A;
      byte_reg[2]   <= `HECD_DEF_FLAGS_B;
      byte_reg[3]   <= `HECD_DEF_PROTECT;
      byte_reg[4]   <= `HECD_DEF_LANGS;
      byte_reg[5]   <= `HECD_DEF_STRINGS;
      byte_reg[6]   <= `HECD_DEF_ACTIVE;
      byte_reg[7]   <= `HECD_DEF_REMOVABLE;
      for (int j = 0; j < 31; j++) begin
        lang_reg[j] <= 16'h0000;
      end
    end else begin
      state_reg     <= state_next;
      marker_ok_reg <= marker_ok_next;
      byte_reg      <= byte_next;
      lang_reg      <= lang_next;
    end
  end

  // Field decode; reserved bits are masked away.
  logic [7:0] flags_a;
  logic [7:0] flags_b;
  assign flags_a = byte_reg[1] & `HECD_FLAGS_A_MASK;
  assign flags_b = byte_reg[2];

  always_comb begin
    cfg.power_good_delay       = byte_reg[0];
    cfg.accept_zero_desc_type  = flags_a[7];
    cfg.compound_flag          = flags_a[6];
    cfg.full_speed_only        = flags_a[5];
    cfg.indicators_off         = flags_a[4];
    cfg.shared_power_switch    = flags_a[2];
    cfg.amber_level_sel        = flags_b[7];
    cfg.green_level_sel        = flags_b[6];
    cfg.local_supply_capable   = flags_b[5];
    cfg.indicator_chop_en      = flags_b[4];
    cfg.power_switch_level_sel = flags_b[3];
    cfg.fault_input_level_sel  = flags_b[2];
    cfg.fault_detect_disable   = flags_b[1];
    cfg.fault_per_port_sel     = flags_b[0];
    cfg.write_protected        = (byte_reg[3] == `HECD_PROTECT_MARKER);
    cfg.language_count         = byte_reg[4];
    cfg.strings_enabled        = (byte_reg[4] != 8'h00) && (byte_reg[4] <= `HECD_MAX_LANGS);
    cfg.string_presence_mask   = 6'(byte_reg[5] & `HECD_STRINGS_MASK);
    cfg.usable_port_mask       = byte_reg[6][3:0];
    cfg.detachable_port_mask   = byte_reg[7][3:0];
  end

  assign config_ready       = (state_reg == HECD_ST_DONE);
  assign eeprom_write_allow = !cfg.write_protected;
  assign desc_type_ok       = (desc_req_type == `HECD_HUB_DESC_TYPE) ||
                              (desc_req_type == 8'h00 && cfg.accept_zero_desc_type);

  // Hub characteristics: power switching, compound, overcurrent mode, indicators.
  always_comb begin
    hub_characteristics     = 16'h0000;
    hub_characteristics[1:0] = cfg.shared_power_switch ? 2'b00 : 2'b01;
    hub_characteristics[2]  = cfg.compound_flag;
    hub_characteristics[3]  = cfg.fault_per_port_sel;
    hub_characteristics[4]  = cfg.fault_detect_disable;
    hub_characteristics[7]  = !cfg.indicators_off;
  end

  // Port count and logical numbering.
  assign port_count = 3'(cfg.usable_port_mask[0]) + 3'(cfg.usable_port_mask[1]) +
                      3'(cfg.usable_port_mask[2]) + 3'(cfg.usable_port_mask[3]);
  assign device_removable = {cfg.detachable_port_mask, 1'b0};

  // Chop timer for indicator modulation.
  always_comb begin
    chop_cnt_next   = chop_cnt_reg + 17'd1;
    chop_phase_next = chop_phase_reg;
    if (chop_cnt_reg >= 17'(CHOP_HALF_CYCLES - 1)) begin
      chop_cnt_next   = 17'd0;
      chop_phase_next = !chop_phase_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chop_cnt_reg   <= 17'd0;
      chop_phase_reg <= 1'b0;
    end else begin
      chop_cnt_reg   <= chop_cnt_next;
      chop_phase_reg <= chop_phase_next;
    end
  end

  logic       chop_gate;
  logic [3:0] fault_raw;
  logic       fault_any;
  assign chop_gate = !cfg.indicator_chop_en || chop_phase_reg;
  assign fault_raw = (cfg.fault_input_level_sel ? fault_in : ~fault_in) & cfg.usable_port_mask;
  assign fault_any = |fault_raw;

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_port
      logic amber_on;
      logic green_on;
      assign amber_on = ctrl_reg[4 + p] && !cfg.indicators_off && chop_gate && config_ready;
      assign green_on = ctrl_reg[8 + p] && !cfg.indicators_off && chop_gate && config_ready;
      assign amber_out[p] = cfg.amber_level_sel ? amber_on : !amber_on;
      assign green_out[p] = cfg.green_level_sel ? green_on : !green_on;
      assign power_out[p] = cfg.power_switch_level_sel ? (ctrl_reg[p] && config_ready) :
                            !(ctrl_reg[p] && config_ready);
      assign port_fault[p] = !cfg.fault_detect_disable &&
                             (cfg.fault_per_port_sel ? fault_raw[p] : fault_any);
      if (p == 0) begin : g_first
        assign logical_port_num[2:0] = cfg.usable_port_mask[0] ? 3'd1 : 3'd0;
      end else begin : g_rest
        logic [2:0] below;
        assign below = 3'(cfg.usable_port_mask[p - 1]) + ((p > 1) ? 3'(cfg.usable_port_mask[0]) : 3'd0) +
                       ((p > 2) ? 3'(cfg.usable_port_mask[1]) : 3'd0);
        assign logical_port_num[3 * p +: 3] = cfg.usable_port_mask[p] ? below + 3'd1 : 3'd0;
      end
    end
    for (p = 0; p < 6; p++) begin : g_string
      assign string_index[8 * p +: 8] = (cfg.strings_enabled && cfg.string_presence_mask[p]) ?
                                        8'(p + 1) : 8'h00;
      assign string_table_base[11 * p +: 11] = `HECD_LANG_TABLE_BASE +
                                               11'(cfg.language_count[4:0]) * 11'(2 * (p + 1));
    end
  endgenerate

  // APB slave, zero wait states; read data is captured in the setup cycle.
  logic apb_setup;
  logic apb_write;
  logic known_addr;
  assign apb_setup  = psel && !penable;
  assign apb_write  = psel && penable && pwrite;
  assign known_addr = (paddr <= `HECD_REG_TABLE_BASE) && (paddr[1:0] == 2'b00);
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !known_addr;
  assign prdata     = rdata_reg;

  always_comb begin
    ctrl_next     = ctrl_reg;
    lang_sel_next = lang_sel_reg;
    rdata_next    = rdata_reg;
    if (apb_write && paddr == `HECD_REG_PORT_CTRL) begin
      ctrl_next = pwdata[11:0];
    end
    if (apb_write && paddr == `HECD_REG_LANG_SEL) begin
      lang_sel_next = pwdata[4:0];
    end
    if (apb_setup) begin
      case (paddr)
        `HECD_REG_STATUS:     rdata_next = {29'h0000_0000, cfg.write_protected, marker_ok_reg, config_ready};
        `HECD_REG_CFG_LOW:    rdata_next = {byte_reg[3], flags_b, flags_a, byte_reg[0]};
        `HECD_REG_CFG_HIGH:   rdata_next = {byte_reg[7], byte_reg[6], byte_reg[5], byte_reg[4]};
        `HECD_REG_HUB_CHAR:   rdata_next = {13'h0000, port_count, hub_characteristics};
        `HECD_REG_PORT_CTRL:  rdata_next = {20'h0_0000, ctrl_reg};
        `HECD_REG_FAULT:      rdata_next = {28'h000_0000, port_fault};
        `HECD_REG_LANG_SEL:   rdata_next = {27'h000_0000, lang_sel_reg};
        `HECD_REG_LANG_CODE:  rdata_next = (lang_sel_reg == 5'd31) ? 32'h0000_0000 :
                                           {16'h0000, lang_reg[lang_sel_reg]};
        `HECD_REG_TABLE_BASE: rdata_next = {21'h00_0000, string_table_base[10:0]};
        default:              rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= 12'h000;
      lang_sel_reg <= 5'd0;
      rdata_reg    <= 32'h0000_0000;
    end else begin
      ctrl_reg     <= ctrl_next;
      lang_sel_reg <= lang_sel_next;
      rdata_reg    <= rdata_next;
    end
  end

  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_marker_gate;
    load_byte_valid && load_byte_addr == `HECD_BYTE_DELAY && !marker_ok_reg && !config_ready
      |=> $stable(byte_reg[0]);
  endproperty
  a_marker_gate: assert property (p_marker_gate) else $error("byte taken without marker");

  property p_latch_once;
    config_ready |=> config_ready && $stable(byte_reg[1]) && $stable(byte_reg[2]);
  endproperty
  a_latch_once: assert property (p_latch_once) else $error("config changed after load");

  property p_zero_desc;
    desc_req_type == 8'h00 |-> desc_type_ok == flags_a[7];
  endproperty
  a_zero_desc: assert property (p_zero_desc) else $error("zero descriptor type wrong");

  property p_ind_off;
    cfg.indicators_off |-> amber_out == {4{!cfg.amber_level_sel}} && !hub_characteristics[7];
  endproperty
  a_ind_off: assert property (p_ind_off) else $error("indicators not off");

  property p_chop;
    cfg.indicator_chop_en && !chop_phase_reg |-> green_out == {4{!cfg.green_level_sel}};
  endproperty
  a_chop: assert property (p_chop) else $error("chop gate failed");

  property p_fault_off;
    cfg.fault_detect_disable |-> port_fault == 4'h0 && hub_characteristics[4];
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault not disabled");

  property p_protect;
    (byte_reg[3] == `HECD_PROTECT_MARKER) |-> !eeprom_write_allow;
  endproperty
  a_protect: assert property (p_protect) else $error("write not refused");

  property p_strings_off;
    (byte_reg[4] == 8'h00 || byte_reg[4] > 8'h1F) |-> string_index == 48'h0000_0000_0000;
  endproperty
  a_strings_off: assert property (p_strings_off) else $error("strings not disabled");

  property p_ports;
    port_count == 3'($countones(cfg.usable_port_mask));
  endproperty
  a_ports: assert property (p_ports) else $error("port count mismatch");

  property p_power_level;
    !config_ready |-> power_out == {4{!cfg.power_switch_level_sel}};
  endproperty
  a_power_level: assert property (p_power_level) else $error("power level wrong");

  c_load_done: cover property (!config_ready ##1 config_ready);
  c_marker: cover property (marker_ok_reg && config_ready);
  c_apb_err: cover property (pslverr);
  c_chop_flip: cover property (cfg.indicator_chop_en && $changed(chop_phase_reg));

endmodule // hecd_decoder

/* File: hw/hecd_end.sv */
`timescale 1ns/100ps

/* File: verification/hecd_eeprom_model.sv */
// Purpose: Serial EEPROM stand-in that streams a configuration image into the decoder.
// Assumes: The bench fills image bytes 0 to 47 before it raises start.
// Notes: Streams bytes 0 to 63 on back-to-back cycles, then pulses load_done.
`timescale 1ns/100ps
module hecd_eeprom_model (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Request to read the image.
  input  wire logic        start,
  // Byte stream to the decoder.
  output logic             load_byte_valid,
  output logic [10:0]      load_byte_addr,
  output logic [7:0]       load_byte_data,
  output logic             load_done
);
  logic [7:0] image [0:63];
  logic [5:0] pos_reg;
  logic       run_reg;

  // A stored string: length in bytes, then the string type code, then Unicode text.
  initial begin
    for (int i = 52; i < 64; i++) begin
      image[i] = 8'h00;
    end
    image[48] = 8'h04;
    image[49] = 8'h03;
    image[50] = 8'h41;
    image[51] = 8'h00;
  end

  // Byte 0, which holds the load marker, is always sent first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg   <= 1'b0;
      pos_reg   <= 6'd0;
      load_done <= 1'b0;
    end else begin
      load_done <= run_reg && (pos_reg == 6'd63);
      if (run_reg) begin
        pos_reg <= pos_reg + 6'd1;
        run_reg <= (pos_reg != 6'd63);
      end else begin
        run_reg <= start;
      end
    end
  end

  // Outside a read the lines carry the inverse of byte 0 and its address, never a held value.
  assign load_byte_valid = run_reg;
  assign load_byte_addr  = run_reg ? {5'd0, pos_reg} : ~{5'd0, pos_reg};
  assign load_byte_data  = run_reg ? image[pos_reg] : ~image[pos_reg];
endmodule // hecd_eeprom_model

/* File: verification/hecd_decoder_tb_top.sv */
// Purpose: Self-checking bench for the configuration decoder.
// Assumes: APB answers without wait states; chop half period shortened to 4 cycles.
// Notes: Each test resets the block, since the image latches once.
`timescale 1ns/100ps
module hecd_decoder_tb_top;
  import hecd_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, start;
  logic [11:0] paddr, logical_port_num;
  logic [31:0] pwdata, prdata, rdata_val;
  logic        load_byte_valid, load_done, desc_type_ok, config_ready, eeprom_write_allow, err_val;
  logic [10:0] load_byte_addr;
  logic [7:0]  load_byte_data, desc_req_type;
  hecd_cfg_type cfg;
  logic [15:0] hub_characteristics;
  logic [2:0]  port_count;
  logic [4:0]  device_removable;
  logic [47:0] string_index;
  logic [65:0] string_table_base;
  logic [3:0]  amber_out, green_out, power_out, fault_in, port_fault;
  logic [1:0]  seen;
  int          n_errors, tests_run;

  hecd_decoder #(.CHOP_HALF_CYCLES(4), .NUM_PORTS(4)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .load_byte_valid, .load_byte_addr, .load_byte_data, .load_done,
    .desc_req_type, .desc_type_ok, .config_ready, .cfg, .hub_characteristics, .port_count, .device_removable,
    .logical_port_num, .string_index, .string_table_base, .eeprom_write_allow, .amber_out, .green_out,
    .power_out, .fault_in, .port_fault);
  hecd_eeprom_model eep (.pclk, .presetn, .start, .load_byte_valid, .load_byte_addr, .load_byte_data,
    .load_done);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [65:0] got, input logic [65:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_errors++;
    rdata_val = prdata;
    err_val   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdata_val, exp);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic set_img(input logic [7:0] m, input logic [63:0] b);
    for (int i = 0; i < 48; i++) eep.image[i] = 8'h00;
    eep.image[0] = m;
    for (int i = 0; i < 8; i++) eep.image[16 + i] = b[8 * i +: 8];
  endtask

  task automatic load_img();
    int n;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    n = 0;
    while (load_done !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (load_done !== 1'b1) n_errors++;
    repeat (2) @(posedge pclk);
  endtask

  task automatic desc_chk(input logic zero_ok);
    desc_req_type <= 8'h00;
    @(posedge pclk);
    chk(desc_type_ok, zero_ok);
    desc_req_type <= 8'h29;
    @(posedge pclk);
    chk(desc_type_ok, 1'b1);
    desc_req_type <= 8'h05;
    @(posedge pclk);
    chk(desc_type_ok, 1'b0);
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    $display("watchdog expired at %0t", $time);
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    start = 1'b0;
    desc_req_type = 8'h00;
    fault_in = 4'hF;
    do_reset();
    chk(config_ready, 1'b0);
    rd_chk(12'h004, 32'h0000_8032);
    rd_chk(12'h008, 32'h0F0F_0000);
    chk(device_removable, 5'h1E);
    chk(power_out, 4'hF);
    // Active-low sense, summed reporting: one faulting port flags every port.
    fault_in <= 4'b1101;
    @(posedge pclk);
    chk(port_fault, 4'hF);
    rd_chk(12'h014, 32'h0000_000F);
    fault_in <= 4'hF;
    apb(1'b0, 12'h024, 32'h0000_0000);
    chk({err_val, rdata_val}, 33'h1_0000_0000);
    set_img(8'h00, 64'h0000_0000_0000_0011);
    load_img();
    chk(config_ready, 1'b1);
    rd_chk(12'h004, 32'h0000_8032);
    rd_chk(12'h000, 32'h0000_0001);
    $display("test defaults done");

    do_reset();
    set_img(8'hD4, 64'h050D_2502_42CD_FF64);
    eep.image[24] = 8'h09;
    eep.image[25] = 8'h04;
    eep.image[26] = 8'h07;
    eep.image[27] = 8'h04;
    load_img();
    rd_chk(12'h004, 32'h42CD_F464);
    rd_chk(12'h000, 32'h0000_0007);
    rd_chk(12'h00C, 32'h0003_000C);
    rd_chk(12'h020, 32'h0000_001C);
    chk(cfg.power_good_delay, 8'h64);
    desc_chk(1'b1);
    chk(hub_characteristics[2], 1'b1);
    chk(hub_characteristics[7], 1'b0);
    chk(hub_characteristics[1:0], 2'b00);
    chk(hub_characteristics[4:3], 2'b01);
    chk(cfg.full_speed_only, 1'b1);
    chk(eeprom_write_allow, 1'b0);
    chk(port_count, 3'd3);
    chk(logical_port_num, 12'h681);
    chk(device_removable, 5'h0A);
    chk(string_index, 48'h0600_0003_0001);
    chk(string_table_base, {11'd48, 11'd44, 11'd40, 11'd36, 11'd32, 11'd28});
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 12'h018, 32'(i));
      rd_chk(12'h01C, (i == 1) ? 32'h0000_0407 : 32'h0000_0409);
    end
    apb(1'b1, 12'h010, 32'h0000_0F05);
    fault_in <= 4'b0110;
    @(posedge pclk);
    chk(power_out, 4'h5);
    chk({amber_out, green_out}, 8'h00);
    chk(port_fault, 4'b0100);
    rd_chk(12'h010, 32'h0000_0F05);
    rd_chk(12'h014, 32'h0000_0004);
    eep.image[16] = 8'h01;
    load_img();
    chk(cfg.power_good_delay, 8'h64);
    $display("test marker image done");

    do_reset();
    set_img(8'hD4, 64'h0F0F_3F20_0032_0032);
    load_img();
    desc_chk(1'b0);
    chk(cfg.full_speed_only, 1'b0);
    chk(hub_characteristics[7], 1'b1);
    chk(hub_characteristics[1:0], 2'b01);
    chk(hub_characteristics[4:3], 2'b10);
    chk(cfg.local_supply_capable, 1'b1);
    chk(string_index, 48'h0);
    chk(eeprom_write_allow, 1'b1);
    apb(1'b1, 12'h010, 32'h0000_0F01);
    fault_in <= 4'h0;
    @(posedge pclk);
    chk(power_out, 4'hE);
    chk(amber_out, 4'hF);
    chk(port_fault, 4'h0);
    seen = 2'b00;
    repeat (16) begin
      @(posedge pclk);
      if (green_out === 4'h0) seen[0] = 1'b1;
      if (green_out === 4'hF) seen[1] = 1'b1;
    end
    chk(seen, 2'b11);
    $display("test low polarity image done");
    end_sim();
  end
endmodule // hecd_decoder_tb_top
